// [hdl/pmc_power_clock.sv]
// Power-mode, clock-source, unlock and strobe-suppress control logic.
`timescale 1ns/10ps
// What this block does
// RULE1: Power control bit 0 enters idle.
// RULE2: Any interrupt or reset leaves idle.
// RULE3: Power control bit 1 enters stop.
// RULE4: Only external interrupt, reset or a kept-reference power-fail leaves stop.
// RULE5: Band-gap keep-on bit powers reference in stop.
// RULE6: Kept reference lets power-fail wake stop.
// RULE7: Keep-on bit ignored outside stop.
// RULE8: Ring select starts from ring after stop.
// RULE9: Switch to crystal after 65536 crystal clocks.
// RULE10: Ring active flag shows ring supplies clock.
// RULE11: Ring restart resumes under 100 ns.
// RULE12: AA then 55 opens three-cycle window.
// RULE13: Protected writes ignored without unlock.
// RULE14: Protect watchdog, band-gap, memory-size bits.
// RULE15: Strobe suppress keeps strobe off on-chip.
// RULE16: Wake clears idle and stop requests.
module pmc_power_clock (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic anyInterrupt,
  input wire logic externalInterrupt,
  input wire logic powerFailInterrupt,
  input wire logic powerFailReset,
  input wire logic crystalClockTick,
  input wire logic busCycle,
  input wire logic externalDataMove,
  output logic cpuHalt,
  output logic clocksHalted,
  output logic bandgapEnable,
  output logic ringClockSelect,
  output logic addressStrobeEnable,
  output logic [7:0] watchdogControl,
  output logic [2:0] programMemorySize
);
  import pmc_pkg::*;

  pmc_mode_t modeReg, modeNext;
  logic [7:0] powerControlReg;
  logic bandgapKeepOnReg, ringStartSelectReg, ringActiveReg, strobeSuppressReg;
  logic [7:0] watchdogControlReg;
  logic [2:0] programMemorySizeReg;
  logic keyFirstSeenReg;
  logic [1:0] unlockCountReg;
  logic [16:0] handoverCountReg;
  logic unlockOpen, wakeStop, wakeIdle, protWrite;

  // The window is open for a fixed number of cycles after the second key byte.
  assign unlockOpen = (unlockCountReg != 2'h0); // [RULE12]
  // A write inside the window spends it, so only one protected change is allowed.
  assign protWrite = regWrite && unlockOpen; // [RULE13]
  // Stop wakes only from pins or, with reference kept on, from power-fail events.
  assign wakeStop = externalInterrupt // [RULE4]
      || (bandgapKeepOnReg && (powerFailInterrupt || powerFailReset)); // [RULE6]
  assign wakeIdle = anyInterrupt; // [RULE2]

  // Next mode follows the power control requests and the wake events.
  always_comb begin
    modeNext = modeReg;
    unique case (modeReg)
      PMC_RUN: begin
        if (regWrite && regAddr == ADDR_POWER_CONTROL && regWrData[BIT_STOP]) begin
          modeNext = PMC_STOP; // [RULE3]
        end else if (regWrite && regAddr == ADDR_POWER_CONTROL && regWrData[BIT_IDLE]) begin
          modeNext = PMC_IDLE; // [RULE1]
        end
      end
      PMC_IDLE: if (wakeIdle) modeNext = PMC_RUN; // [RULE2]
      PMC_STOP: if (wakeStop) modeNext = PMC_RUN; // [RULE4]
      default: modeNext = PMC_RUN;
    endcase
  end

  // Mode register; reset always returns to run.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) modeReg <= PMC_RUN;
    else modeReg <= modeNext;
  end

  // Power control bits hold the request and are cleared by hardware on wake.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      powerControlReg <= RESET_BYTE;
    end else if (modeReg != PMC_RUN && modeNext == PMC_RUN) begin
      powerControlReg[BIT_IDLE] <= 1'b0; // [RULE16]
      powerControlReg[BIT_STOP] <= 1'b0; // [RULE16]
    end else if (regWrite && regAddr == ADDR_POWER_CONTROL) begin
      powerControlReg <= regWrData;
    end
  end

  // Unlock sequencer: first key arms, second key opens the window.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      keyFirstSeenReg <= 1'b0;
      unlockCountReg <= 2'h0;
    end else if (regWrite && regAddr == ADDR_UNLOCK_KEY) begin
      keyFirstSeenReg <= (regWrData == KEY_FIRST);
      if (keyFirstSeenReg && regWrData == KEY_SECOND) begin
        unlockCountReg <= UNLOCK_WINDOW_CYCLES; // [RULE12]
      end else begin
        unlockCountReg <= 2'h0;
      end
    end else begin
      if (regWrite) keyFirstSeenReg <= 1'b0;
      if (protWrite) unlockCountReg <= 2'h0;
      else if (unlockOpen) unlockCountReg <= unlockCountReg - 2'h1;
    end
  end

  // Ring control: select bit free, keep-on bit protected.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bandgapKeepOnReg <= 1'b0; // [RULE5]
      ringStartSelectReg <= 1'b0;
    end else if (regWrite && regAddr == ADDR_RING_OSC_CONTROL) begin
      ringStartSelectReg <= regWrData[BIT_RING_SELECT]; // [RULE8]
      if (unlockOpen) bandgapKeepOnReg <= regWrData[BIT_BANDGAP]; // [RULE14]
    end
  end

  // Protected watchdog and memory-size bits; unprotected bits write freely.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      watchdogControlReg <= RESET_BYTE;
      programMemorySizeReg <= 3'h0;
    end else if (regWrite && regAddr == ADDR_WATCHDOG_CONTROL) begin
      watchdogControlReg <= unlockOpen ? regWrData // [RULE14]
          : ((watchdogControlReg & WDOG_PROTECT_MASK) | (regWrData & ~WDOG_PROTECT_MASK));
    end else if (regWrite && regAddr == ADDR_PROG_MEM_SIZE && unlockOpen) begin
      programMemorySizeReg <= regWrData[2:0]; // [RULE14]
    end
  end

  // Strobe suppress control.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) strobeSuppressReg <= 1'b0;
    else if (regWrite && regAddr == ADDR_POWER_MGMT) begin
      strobeSuppressReg <= regWrData[BIT_STROBE_SUPPRESS];
    end
  end

  // Ring start on stop exit, then handover after the crystal interval.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ringActiveReg <= 1'b0;
      handoverCountReg <= 17'h00000;
    end else if (modeReg == PMC_STOP && wakeStop) begin
      ringActiveReg <= ringStartSelectReg; // [RULE8] [RULE11]
      handoverCountReg <= 17'h00000;
    end else if (ringActiveReg && crystalClockTick) begin
      if (handoverCountReg == 17'(CRYSTAL_HANDOVER_CLOCKS - 1)) begin
        ringActiveReg <= 1'b0; // [RULE9]
      end
      handoverCountReg <= handoverCountReg + 17'h00001;
    end
  end

  // Register read port, data one cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) regRdData <= RESET_BYTE;
    else if (regRead) begin
      unique case (regAddr)
        ADDR_POWER_CONTROL: regRdData <= powerControlReg;
        ADDR_RING_OSC_CONTROL: regRdData <= {5'h00, ringActiveReg, // [RULE10]
            ringStartSelectReg, bandgapKeepOnReg};
        ADDR_POWER_MGMT: regRdData <= {5'h00, strobeSuppressReg, 2'h0};
        ADDR_WATCHDOG_CONTROL: regRdData <= watchdogControlReg;
        ADDR_PROG_MEM_SIZE: regRdData <= {5'h00, programMemorySizeReg};
        default: regRdData <= RESET_BYTE;
      endcase
    end else regRdData <= RESET_BYTE;
  end

  // Output decode.
  assign cpuHalt = (modeReg != PMC_RUN); // [RULE1] [RULE3]
  assign clocksHalted = (modeReg == PMC_STOP); // [RULE3]
  assign bandgapEnable = (modeReg != PMC_STOP) || bandgapKeepOnReg; // [RULE5] [RULE7]
  assign ringClockSelect = ringActiveReg; // [RULE10]
  assign addressStrobeEnable = busCycle && (!strobeSuppressReg || externalDataMove); // [RULE15]
  assign watchdogControl = watchdogControlReg;
  assign programMemorySize = programMemorySizeReg;

  AST_IDLE_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE1]
    (modeReg == PMC_RUN && regWrite && regAddr == ADDR_POWER_CONTROL
     && regWrData == 8'h01) |=> cpuHalt && !clocksHalted)
    else $error("Idle not entered.");
  AST_IDLE_EXIT: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
    (modeReg == PMC_IDLE && anyInterrupt) |=> !cpuHalt)
    else $error("Idle not left on interrupt.");
  AST_STOP_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
    (modeReg == PMC_STOP && !externalInterrupt && !powerFailInterrupt && !powerFailReset)
    |=> clocksHalted)
    else $error("Stop left without wake source.");
  AST_BG_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE6]
    (modeReg == PMC_STOP && bandgapKeepOnReg && powerFailInterrupt) |=> !clocksHalted)
    else $error("Power-fail did not wake stop.");
  AST_BG_RUN: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE7]
    !clocksHalted |-> bandgapEnable)
    else $error("Reference off outside stop.");
  AST_RING_START: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE11]
    (modeReg == PMC_STOP && externalInterrupt && ringStartSelectReg)
    |=> ringClockSelect && !cpuHalt)
    else $error("Ring restart not immediate.");
  AST_PROTECT: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE13]
    (regWrite && regAddr == ADDR_RING_OSC_CONTROL && !unlockOpen)
    |=> $stable(bandgapKeepOnReg))
    else $error("Protected bit changed while locked.");
  AST_UNLOCK: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE12]
    (regWrite && regAddr == ADDR_UNLOCK_KEY && regWrData == KEY_FIRST)
    ##1 (regWrite && regAddr == ADDR_UNLOCK_KEY && regWrData == KEY_SECOND)
    |=> unlockOpen)
    else $error("Unlock window not opened.");
  AST_WAKE_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE16]
    (modeReg == PMC_STOP && wakeStop) |=> powerControlReg[BIT_STOP] == 1'b0)
    else $error("Stop request not cleared on wake.");
  AST_STROBE: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE15]
    (strobeSuppressReg && !externalDataMove) |-> !addressStrobeEnable)
    else $error("Strobe active on-chip while suppressed.");

  // A stop request from run must halt every clock on the next cycle.
  AST_STOP_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
    (modeReg == PMC_RUN && regWrite && regAddr == ADDR_POWER_CONTROL
     && regWrData[BIT_STOP]) |=> clocksHalted)
    else $error("Stop not entered.");

  // An interrupt that only wakes idle must leave stop untouched.
  AST_STOP_NO_IDLE_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
    (modeReg == PMC_STOP && anyInterrupt && !wakeStop) |=> clocksHalted)
    else $error("Internal interrupt woke stop.");

  // With the reference switched off, power-fail events must not wake stop.
  AST_BG_OFF_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE6]
    (modeReg == PMC_STOP && !bandgapKeepOnReg && !externalInterrupt)
    |=> clocksHalted)
    else $error("Stop left with reference off.");

  // In stop the reference follows the keep-on bit.
  AST_BG_STOP_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
    (clocksHalted && !bandgapKeepOnReg) |-> !bandgapEnable)
    else $error("Reference on in stop without keep-on.");

  // Without the ring selected, the restart waits on the crystal.
  AST_RING_SKIP: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE8]
    (modeReg == PMC_STOP && wakeStop && !ringStartSelectReg) |=> !ringClockSelect)
    else $error("Ring used although not selected.");

  // The last crystal tick of the interval hands the clock back.
  AST_HANDOVER: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE9]
    (ringActiveReg && crystalClockTick && !(modeReg == PMC_STOP && wakeStop)
     && handoverCountReg == 17'(CRYSTAL_HANDOVER_CLOCKS - 1)) |=> !ringClockSelect)
    else $error("Crystal handover missed.");

  // A read of the ring control register shows the ring flag as it stood.
  AST_RING_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE10]
    (regRead && regAddr == ADDR_RING_OSC_CONTROL)
    |=> regRdData[BIT_RING_ACTIVE] == $past(ringActiveReg))
    else $error("Ring flag read wrong.");

  // A protected write other than a key byte closes the window.
  AST_WINDOW_SPENT: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE13]
    (protWrite && regAddr != ADDR_UNLOCK_KEY) |=> !unlockOpen)
    else $error("Window not spent by protected write.");

  // Locked writes must keep the protected watchdog bits.
  AST_WDOG_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE14]
    (regWrite && regAddr == ADDR_WATCHDOG_CONTROL && !unlockOpen)
    |=> (watchdogControlReg & WDOG_PROTECT_MASK)
        == ($past(watchdogControlReg) & WDOG_PROTECT_MASK))
    else $error("Protected watchdog bit changed while locked.");

  // Locked writes must keep the memory-size select.
  AST_PMS_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE14]
    (regWrite && regAddr == ADDR_PROG_MEM_SIZE && !unlockOpen)
    |=> $stable(programMemorySizeReg))
    else $error("Memory size changed while locked.");

  // Leaving idle clears the idle request bit.
  AST_IDLE_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE16]
    (modeReg == PMC_IDLE && wakeIdle) |=> powerControlReg[BIT_IDLE] == 1'b0)
    else $error("Idle request not cleared on wake.");

  COV_STOP_RING: cover property (@(posedge sys_clk) disable iff (!rst_n)
    modeReg == PMC_STOP ##1 ringActiveReg);

  COV_WDOG: cover property (@(posedge sys_clk) disable iff (!rst_n)
    protWrite && regAddr == ADDR_WATCHDOG_CONTROL);

  COV_IDLE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    modeReg == PMC_IDLE ##1 modeReg == PMC_RUN);
  COV_RING: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ringActiveReg ##1 !ringActiveReg);
  COV_PROT: cover property (@(posedge sys_clk) disable iff (!rst_n)
    protWrite && regAddr == ADDR_RING_OSC_CONTROL);
endmodule // pmc_power_clock

// [hdl/pmc_pkg.sv]
// Package with register map, field positions and timing counts for the power-mode clock control.
package pmc_pkg;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'hC7;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_RING_OSC_CONTROL = 8'h85;
  localparam logic [7:0] ADDR_POWER_MGMT = 8'hC4;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'hD8;
  localparam logic [7:0] ADDR_PROG_MEM_SIZE = 8'hC2;
  localparam logic [7:0] KEY_FIRST = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam int BIT_IDLE = 0;
  localparam int BIT_STOP = 1;
  localparam int BIT_BANDGAP = 0;
  localparam int BIT_RING_SELECT = 1;
  localparam int BIT_RING_ACTIVE = 2;
  localparam int BIT_STROBE_SUPPRESS = 2;
  localparam logic [7:0] WDOG_PROTECT_MASK = 8'h4B;
  localparam logic [7:0] PMS_PROTECT_MASK = 8'h07;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] UNLOCK_WINDOW_CYCLES = 2'h3;
  localparam int CRYSTAL_HANDOVER_CLOCKS = 65536;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int RING_RESUME_MAX_PS = 100000;
  localparam int RING_RESUME_CYCLES = RING_RESUME_MAX_PS / CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_IDLE,
    PMC_STOP
  } pmc_mode_t;
endpackage : pmc_pkg

// [testbench/tb_power_mode_clock_control.sv]
// Self-checking testbench for the power-mode and clock-source control block.
`timescale 1ns/10ps
module tb_power_mode_clock_control;
  import pmc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdData;
  logic anyInterrupt = 1'b0;
  logic externalInterrupt = 1'b0;
  logic powerFailInterrupt = 1'b0;
  logic crystalClockTick = 1'b0;
  logic busCycle = 1'b0;
  logic externalDataMove = 1'b0;
  logic cpuHalt, clocksHalted, bandgapEnable, ringClockSelect, addressStrobeEnable;
  logic [7:0] watchdogControl;
  logic [2:0] programMemorySize;
  int failCount = 0;
  int nTests = 0;

  // Clock at 125 MHz.
  always #4 sys_clk = ~sys_clk;

  pmc_power_clock uut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .anyInterrupt(anyInterrupt), .externalInterrupt(externalInterrupt),
    .powerFailInterrupt(powerFailInterrupt), .powerFailReset(1'b0),
    .crystalClockTick(crystalClockTick), .busCycle(busCycle),
    .externalDataMove(externalDataMove), .cpuHalt(cpuHalt), .clocksHalted(clocksHalted),
    .bandgapEnable(bandgapEnable), .ringClockSelect(ringClockSelect),
    .addressStrobeEnable(addressStrobeEnable), .watchdogControl(watchdogControl),
    .programMemorySize(programMemorySize));

  // Compares one byte-wide result and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write cycle; the strobe stays up so writes may follow with no gap.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrite <= 1'b1;
    regRead <= 1'b0;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
  endtask

  // One read cycle; data is checked in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regRead <= 1'b1;
    regWrite <= 1'b0;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask

  // One quiet bus cycle, then lets the edge's updates settle.
  task automatic idle();
    regWrite <= 1'b0;
    regRead <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  // Opens the protected-write window with the two key bytes.
  task automatic unlock();
    wr(ADDR_UNLOCK_KEY, KEY_FIRST);
    wr(ADDR_UNLOCK_KEY, KEY_SECOND);
  endtask

  // Holds the chosen wake sources {any, external, power-fail} for one cycle.
  task automatic wake(input logic [2:0] v);
    {anyInterrupt, externalInterrupt, powerFailInterrupt} <= v;
    @(posedge sys_clk);
    {anyInterrupt, externalInterrupt, powerFailInterrupt} <= 3'h0;
    #1;
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs about 66000 cycles.
  initial begin
    #600000;
    failCount++;
    end_sim();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ADDR_RING_OSC_CONTROL, 8'h00);
    chk({6'h00, bandgapEnable, cpuHalt}, 8'h02);
    wr(ADDR_RING_OSC_CONTROL, 8'h01);
    rd(ADDR_RING_OSC_CONTROL, 8'h00);
    unlock();
    wr(ADDR_RING_OSC_CONTROL, 8'h01);
    rd(ADDR_RING_OSC_CONTROL, 8'h01);
    wr(ADDR_UNLOCK_KEY, KEY_FIRST);
    wr(ADDR_PROG_MEM_SIZE, 8'h00);
    wr(ADDR_UNLOCK_KEY, KEY_SECOND);
    wr(ADDR_PROG_MEM_SIZE, 8'h05);
    idle();
    chk({5'h00, programMemorySize}, 8'h00);
    unlock();
    wr(ADDR_PROG_MEM_SIZE, 8'h05);
    unlock();
    wr(ADDR_WATCHDOG_CONTROL, WDOG_PROTECT_MASK);
    idle();
    chk({5'h00, programMemorySize}, 8'h05);
    chk(watchdogControl & WDOG_PROTECT_MASK, WDOG_PROTECT_MASK);
    // Idle entry and wake by any interrupt.
    wr(ADDR_POWER_CONTROL, 8'h01);
    idle();
    chk({5'h00, cpuHalt, clocksHalted, bandgapEnable}, 8'h05);
    wake(3'h4);
    chk({7'h00, cpuHalt}, 8'h00);
    rd(ADDR_POWER_CONTROL, 8'h00);
    // Stop with the reference kept on: power-fail wakes, a timer-class one does not.
    wr(ADDR_POWER_CONTROL, 8'h02);
    idle();
    chk({6'h00, clocksHalted, bandgapEnable}, 8'h03);
    wake(3'h4);
    chk({7'h00, clocksHalted}, 8'h01);
    wake(3'h1);
    chk({6'h00, clocksHalted, ringClockSelect}, 8'h00);
    rd(ADDR_POWER_CONTROL, 8'h00);
    // Stop with the reference off and the ring chosen as restart clock.
    unlock();
    wr(ADDR_RING_OSC_CONTROL, 8'h02);
    wr(ADDR_POWER_CONTROL, 8'h02);
    idle();
    chk({6'h00, clocksHalted, bandgapEnable}, 8'h02);
    wake(3'h1);
    chk({7'h00, clocksHalted}, 8'h01);
    wake(3'h2);
    chk({6'h00, clocksHalted, ringClockSelect}, 8'h01);
    rd(ADDR_RING_OSC_CONTROL, 8'h06);
    // Handover to the crystal after the full tick count, not one tick early.
    crystalClockTick <= 1'b1;
    repeat (CRYSTAL_HANDOVER_CLOCKS - 1) @(posedge sys_clk);
    crystalClockTick <= 1'b0;
    #1;
    chk({7'h00, ringClockSelect}, 8'h01);
    crystalClockTick <= 1'b1;
    @(posedge sys_clk);
    crystalClockTick <= 1'b0;
    idle();
    chk({7'h00, ringClockSelect}, 8'h00);
    rd(ADDR_RING_OSC_CONTROL, 8'h02);
    // Address strobe suppression for on-chip cycles only.
    busCycle <= 1'b1;
    idle();
    chk({7'h00, addressStrobeEnable}, 8'h01);
    wr(ADDR_POWER_MGMT, 8'h04);
    idle();
    chk({7'h00, addressStrobeEnable}, 8'h00);
    externalDataMove <= 1'b1;
    idle();
    chk({7'h00, addressStrobeEnable}, 8'h01);
    end_sim();
  end
endmodule // tb_power_mode_clock_control
